/* design/tcps_debounce.sv */
// debouncer: passes a vector once it has held steady for a set count
`timescale 1ns/10ps
module tcps_debounce #(
	parameter int W = 6,
	parameter int CYC = 2500
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q,
	output logic stable
);
	logic [W-1:0] last;
	logic [W-1:0] next_last;
	logic [W-1:0] next_q;
	logic [11:0] cnt;
	logic [11:0] next_cnt;
	logic next_stable;

	// restart the count on any change, release after the full count
	always_comb begin
		next_last = d;
		next_q = q;
		next_cnt = cnt;
		next_stable = stable;
		if (d != last) begin
			next_cnt = 12'h000;
			next_stable = 1'b0;
		end else if (cnt == 12'(CYC - 1)) begin
			next_q = last;
			next_stable = 1'b1;
		end else begin
			next_cnt = cnt + 12'h001;
		end
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= '0;
			q <= '0;
			cnt <= 12'h000;
			stable <= 1'b0;
		end else begin
			last <= next_last;
			q <= next_q;
			cnt <= next_cnt;
			stable <= next_stable;
		end
	end
endmodule // tcps_debounce

/* design/tcps_pkg.sv */
// constants, types and register map of the type-c port status and control block
package tcps_pkg;

	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_PINS = 8'h0C;

	// control register fields
	localparam int CTRL_ADV_LSB = 0;
	localparam logic [1:0] CTRL_ADV_RESET = 2'h0;

	// flag register fields, write one to clear
	localparam int FLAG_INT_BIT = 0;
	localparam int FLAG_FAULT_BIT = 1;

	// status register fields
	localparam int ST_DET_LSB = 0;
	localparam int ST_ACC_LSB = 2;
	localparam int ST_VCONN_BIT = 5;
	localparam int ST_SNK_BIT = 6;
	localparam int ST_SRC_BIT = 7;
	localparam int ST_STRAP_BIT = 8;
	localparam int ST_ADDR6_BIT = 9;
	localparam int ST_BLOCK_BIT = 10;
	localparam int ST_W = 11;

	// accessory kind codes
	localparam logic [2:0] ACC_NONE = 3'h0;
	localparam logic [2:0] ACC_AUDIO = 3'h4;
	localparam logic [2:0] ACC_DBG_SRC = 3'h6;
	localparam logic [2:0] ACC_DBG_SNK = 3'h7;

	// three-level interface select pin codes
	localparam logic [1:0] SEL_LOW = 2'h0;
	localparam logic [1:0] SEL_FLOAT = 2'h1;
	localparam logic [1:0] SEL_HIGH = 2'h2;

	// port configuration codes
	localparam logic [1:0] CFG_SRC = 2'h0;
	localparam logic [1:0] CFG_SNK = 2'h1;
	localparam logic [1:0] CFG_DRP = 2'h2;

	// timing
	localparam int CLK_MHZ = 25;
	localparam int CC_DEBOUNCE_US = 100;
	localparam int CC_DEBOUNCE_CYC = CC_DEBOUNCE_US * CLK_MHZ;
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	typedef enum logic [2:0] {CC_OPEN, CC_RA, CC_RD, CC_RP_DEF, CC_RP_MED, CC_RP_HIGH} tcps_cc_t;
	typedef enum logic [1:0] {CUR_DEF, CUR_MED, CUR_HIGH} tcps_cur_t;
	typedef enum {VC_OFF, VC_ON, VC_BLOCK} tcps_vc_t;

endpackage

/* design/tcps_port_status.sv */
// type-c port status and control: current level, accessories, vconn, mode and status pins
`timescale 1ns/10ps
module tcps_port_status (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] cc1_level,
	input wire logic [2:0] cc2_level,
	input wire logic [1:0] port_cfg,
	input wire logic [1:0] if_sel,
	input wire logic [1:0] cur_sel,
	input wire logic bus_power_sense,
	input wire logic vconn_ocp,
	input wire logic role_source,
	input wire logic attached_src,
	input wire logic attached_snk,
	output logic [1:0] rp_strength,
	output logic vconn_cc1_en,
	output logic vconn_cc2_en,
	output logic charge_through_en,
	output logic strap_mode,
	output logic target_addr_bit6,
	input wire logic current_code_out_a_in,
	output logic current_code_out_a_drv,
	output logic current_code_out_a_oe,
	input wire logic current_code_out_b_in,
	output logic current_code_out_b_drv,
	output logic current_code_out_b_oe,
	input wire logic audio_detect_out_in,
	output logic audio_detect_out_drv,
	output logic audio_detect_out_oe
);
	import tcps_pkg::*;

	logic [16:0] sync_q;
	logic [5:0] cc_db;
	logic cc_stable;
	tcps_cc_t cc1, cc2;
	logic [1:0] s_cfg, s_if_sel, s_cur_sel;
	logic vbus, ocp_s, ocp_q, ocp_rise;
	logic [2:0] s_pins;
	logic [1:0] strap_cnt, next_strap_cnt;
	logic strap_done, next_strap_done, next_strap_mode, next_addr6;
	logic src_role, snk_role, sink_att, src_att, audio, dbg_src, dbg_snk;
	logic [2:0] acc_kind;
	tcps_cur_t det_level, adv_sel;
	logic vconn_req, req_side;
	tcps_vc_t vc_state, next_vc_state;
	logic vc_side, next_vc_side, seen_detach, next_seen_detach;
	logic [1:0] ctrl_adv, next_ctrl_adv;
	logic int_pending, next_int_pending, fault_flag, next_fault_flag;
	logic [ST_W-1:0] status_now, status_q;
	logic [1:0] next_rp;
	logic wr_en, new_info;

	// pin levels cross into the clock domain first; the role and attach inputs are used unsynchronised
	tcps_sync #(.W(17)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d({cc1_level, cc2_level, port_cfg, if_sel, cur_sel, bus_power_sense, vconn_ocp,
			current_code_out_a_in, current_code_out_b_in, audio_detect_out_in}),
		.q(sync_q)
	);
	assign s_cfg = sync_q[10:9];
	assign s_if_sel = sync_q[8:7];
	assign s_cur_sel = sync_q[6:5];
	assign vbus = sync_q[4];
	assign ocp_s = sync_q[3];
	assign s_pins = sync_q[2:0];

	tcps_debounce #(.W(6), .CYC(CC_DEBOUNCE_CYC)) u_deb (
		.pclk(pclk),
		.presetn(presetn),
		.d(sync_q[16:11]),
		.q(cc_db),
		.stable(cc_stable)
	);
	assign cc1 = tcps_cc_t'(cc_db[5:3]);
	assign cc2 = tcps_cc_t'(cc_db[2:0]);
	function automatic logic is_rp(input tcps_cc_t c);
		is_rp = (c == CC_RP_DEF) || (c == CC_RP_MED) || (c == CC_RP_HIGH);
	endfunction
	function automatic tcps_cur_t rp_level(input tcps_cc_t c);
		case (c)
			CC_RP_MED: rp_level = CUR_MED;
			CC_RP_HIGH: rp_level = CUR_HIGH;
			default: rp_level = CUR_DEF;
		endcase
	endfunction

	// catch interface select once, after the synchroniser settles
	always_comb begin
		next_strap_cnt = strap_cnt;
		next_strap_done = strap_done;
		next_strap_mode = strap_mode;
		next_addr6 = target_addr_bit6;
		if (!strap_done) begin
			if (strap_cnt == STRAP_WAIT) begin
				next_strap_done = 1'b1;
				next_strap_mode = (s_if_sel == SEL_FLOAT);
				next_addr6 = (s_if_sel == SEL_HIGH);
			end else begin
				next_strap_cnt = strap_cnt + 2'h1;
			end
		end
	end

	// strap registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_cnt <= 2'h0;
			strap_done <= 1'b0;
			strap_mode <= 1'b1;
			target_addr_bit6 <= 1'b0;
		end else begin
			strap_cnt <= next_strap_cnt;
			strap_done <= next_strap_done;
			strap_mode <= next_strap_mode;
			target_addr_bit6 <= next_addr6;
		end
	end

	// attach, role and accessory detection
	always_comb begin
		src_role = (s_cfg == CFG_SRC) || ((s_cfg == CFG_DRP) && role_source);
		// dual role resolves to sink only with bus power
		snk_role = (s_cfg == CFG_SNK) || ((s_cfg == CFG_DRP) && !role_source && vbus);
		// sink attach waits for stable cc and bus power
		sink_att = attached_snk && snk_role && cc_stable && vbus && (is_rp(cc1) || is_rp(cc2));
		src_att = attached_src && src_role && ((cc1 == CC_RD) || (cc2 == CC_RD));
		// passive audio needs Ra on both
		audio = cc_stable && (cc1 == CC_RA) && (cc2 == CC_RA);
		dbg_src = cc_stable && src_role && (cc1 == CC_RD) && (cc2 == CC_RD);
		// debug as sink, gated by bus power
		dbg_snk = cc_stable && snk_role && vbus && is_rp(cc1) && is_rp(cc2);
		if (audio) begin
			acc_kind = ACC_AUDIO;
		end else if (dbg_snk) begin
			acc_kind = ACC_DBG_SNK;
		end else if (dbg_src) begin
			acc_kind = ACC_DBG_SRC;
		end else begin
			acc_kind = ACC_NONE;
		end
		if (!sink_att) begin
			det_level = CUR_DEF;
		end else if (is_rp(cc1)) begin
			det_level = rp_level(cc1);
		end else begin
			det_level = rp_level(cc2);
		end
		adv_sel = strap_mode ? tcps_cur_t'(s_cur_sel) : tcps_cur_t'(ctrl_adv);
		// vconn request: attached source, Rd one side, Ra other
		vconn_req = src_att && src_role
			&& (((cc1 == CC_RD) && (cc2 == CC_RA)) || ((cc2 == CC_RD) && (cc1 == CC_RA)));
		req_side = (cc1 == CC_RD);
		ocp_rise = ocp_s && !ocp_q;
	end
	assign charge_through_en = dbg_src && (s_cfg == CFG_SRC);

	// vconn switch control
	always_comb begin
		next_vc_state = vc_state;
		next_vc_side = vc_side;
		next_seen_detach = seen_detach;
		case (vc_state)
			VC_OFF: begin
				if (vconn_req && !fault_flag) begin
					next_vc_state = VC_ON;
					next_vc_side = req_side;
				end
			end
			VC_ON: begin
				if (ocp_rise) begin
					next_vc_state = VC_BLOCK;
					next_seen_detach = 1'b0;
				// withdraw on detach with cable gone
				end else if (!attached_src && ((vc_side ? cc2 : cc1) != CC_RA)) begin
					next_vc_state = VC_OFF;
				end
			end
			VC_BLOCK: begin
				if (!strap_mode) begin
					if (!fault_flag) begin
						next_vc_state = VC_OFF;
					end
				end else begin
					// held off until detach then re-attach
					if (!attached_src) begin
						next_seen_detach = 1'b1;
					end else if (seen_detach) begin
						next_vc_state = VC_OFF;
					end
				end
			end
			default: next_vc_state = VC_OFF;
		endcase
	end

	// vconn registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vc_state <= VC_OFF;
			vc_side <= 1'b0;
			seen_detach <= 1'b0;
			ocp_q <= 1'b0;
		end else begin
			vc_state <= next_vc_state;
			vc_side <= next_vc_side;
			seen_detach <= next_seen_detach;
			ocp_q <= ocp_s;
		end
	end
	assign vconn_cc1_en = (vc_state == VC_ON) && !vc_side;
	assign vconn_cc2_en = (vc_state == VC_ON) && vc_side;
	// status word as software sees it
	assign status_now = {vc_state == VC_BLOCK, target_addr_bit6, strap_mode, src_att, sink_att,
		vc_state == VC_ON, acc_kind, det_level};
	assign wr_en = psel && penable && pwrite;
	assign new_info = strap_done && !strap_mode && (status_now != status_q);
	// register file next values
	always_comb begin
		next_ctrl_adv = ctrl_adv;
		next_int_pending = int_pending;
		next_fault_flag = fault_flag;
		next_rp = src_att ? adv_sel : CUR_DEF;
		if (wr_en && (paddr == ADDR_CTRL)) begin
			next_ctrl_adv = pwdata[CTRL_ADV_LSB +: 2];
		end
		if (wr_en && (paddr == ADDR_FLAGS)) begin
			if (pwdata[FLAG_INT_BIT]) begin
				next_int_pending = 1'b0;
			end
			if (pwdata[FLAG_FAULT_BIT]) begin
				next_fault_flag = 1'b0;
			end
		end
		// new info sets pending, set wins
		if (new_info) begin
			next_int_pending = 1'b1;
		end
		if (ocp_rise && !strap_mode && (vc_state == VC_ON)) begin
			next_fault_flag = 1'b1;
		end
	end

	// register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_adv <= CTRL_ADV_RESET;
			int_pending <= 1'b0;
			fault_flag <= 1'b0;
			status_q <= '0;
			rp_strength <= CUR_DEF;
		end else begin
			ctrl_adv <= next_ctrl_adv;
			int_pending <= next_int_pending;
			fault_flag <= next_fault_flag;
			status_q <= status_now;
			rp_strength <= next_rp;
		end
	end

	// apb read and answer, zero wait states
	always_comb begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			ADDR_CTRL: prdata = {30'h0000_0000, ctrl_adv};
			ADDR_STATUS: prdata = {21'h00_0000, status_q};
			ADDR_FLAGS: prdata = {30'h0000_0000, fault_flag, int_pending};
			ADDR_PINS: prdata = {29'h0000_0000, s_pins};
			default: pslverr = psel && penable;
		endcase
	end
	assign pready = 1'b1;

	// open-drain pins only ever pull low
	assign current_code_out_a_drv = 1'b0;
	assign current_code_out_b_drv = 1'b0;
	assign audio_detect_out_drv = 1'b0;
	assign current_code_out_a_oe = strap_mode && strap_done && (status_q[ST_DET_LSB +: 2] != CUR_DEF);
	assign current_code_out_b_oe = strap_mode && strap_done && (status_q[ST_DET_LSB +: 2] == CUR_HIGH);
	// audio pin in strap mode, interrupt otherwise
	assign audio_detect_out_oe = strap_mode ? (strap_done && (status_q[ST_ACC_LSB +: 3] == ACC_AUDIO))
		: int_pending;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_fault_set; ocp_rise && !strap_mode && (vc_state == VC_ON)
		|=> fault_flag && !vconn_cc1_en && !vconn_cc2_en; endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault did not latch");
	property p_fault_hold; fault_flag && !strap_mode |-> !vconn_cc1_en && !vconn_cc2_en; endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("vconn on with fault");
	property p_strap_block; (vc_state == VC_BLOCK) && strap_mode && attached_src && !seen_detach
		|=> vc_state == VC_BLOCK; endproperty
	a_strap_block: assert property (p_strap_block) else $error("block left early");
	property p_vconn_cause; $rose(vc_state == VC_ON) |-> $past(vconn_req); endproperty
	a_vconn_cause: assert property (p_vconn_cause) else $error("vconn without cause");
	property p_adv_after_attach; rp_strength != CUR_DEF |-> $past(src_att); endproperty
	a_adv_after_attach: assert property (p_adv_after_attach) else $error("early advert");
	property p_code_high; strap_mode && strap_done && (status_q[ST_DET_LSB +: 2] == CUR_HIGH)
		|-> current_code_out_a_oe && current_code_out_b_oe; endproperty
	a_code_high: assert property (p_code_high) else $error("high code wrong");
	property p_int_set; new_info |=> int_pending && audio_detect_out_oe; endproperty
	a_int_set: assert property (p_int_set) else $error("pending not set");
	property p_dbg_snk; dbg_snk && !audio |=> status_q[ST_ACC_LSB +: 3] == 3'h7; endproperty
	a_dbg_snk: assert property (p_dbg_snk) else $error("debug kind wrong");
	property p_mode_held; strap_done |=> $stable(strap_mode) && $stable(target_addr_bit6); endproperty
	a_mode_held: assert property (p_mode_held) else $error("mode changed");
	property p_sink_vbus; sink_att |-> vbus && cc_stable; endproperty
	a_sink_vbus: assert property (p_sink_vbus) else $error("sink attach without bus power");
endmodule // tcps_port_status

/* design/tcps_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module tcps_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	// first stage feeds only the second
	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	// stage registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule // tcps_sync

/* verification/tcps_far_port.sv */
// far-side port model: cc terminations, bus power and vconn overcurrent
`timescale 1ns/10ps
module tcps_far_port
import tcps_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] kind,
	input wire logic [1:0] rp_lvl,
	input wire logic [7:0] vbus_lag,
	input wire logic ocp_req,
	output logic [2:0] cc1_level,
	output logic [2:0] cc2_level,
	output logic bus_power_sense,
	output logic vconn_ocp
);
	logic [7:0] cnt;
	logic [2:0] rp;
	logic src;
	// terminations per kind: 0 none,1 sink,2 sink+cable,3 audio,4 rd debug,5 source,6 rp debug,7 one ra
	always_comb begin
		rp = 3'h3 + {1'b0, rp_lvl};
		src = (kind == 3'h5) || (kind == 3'h6);
		case (kind)
			3'h1: {cc1_level, cc2_level} = {CC_RD, CC_OPEN};
			3'h2: {cc1_level, cc2_level} = {CC_RD, CC_RA};
			3'h3: {cc1_level, cc2_level} = {CC_RA, CC_RA};
			3'h4: {cc1_level, cc2_level} = {CC_RD, CC_RD};
			3'h5: {cc1_level, cc2_level} = {rp, CC_OPEN};
			3'h6: {cc1_level, cc2_level} = {rp, rp};
			3'h7: {cc1_level, cc2_level} = {CC_RA, CC_OPEN};
			default: {cc1_level, cc2_level} = {CC_OPEN, CC_OPEN};
		endcase
	end
	// a far source raises bus power after a lag, drops it at once on detach
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
		end else if (!src) begin
			cnt <= 8'h00;
		end else if (cnt != 8'hFF) begin
			cnt <= cnt + 8'h01;
		end
	end
	assign bus_power_sense = src && (cnt >= vbus_lag);
	assign vconn_ocp = ocp_req; // cable overload on command
endmodule // tcps_far_port

/* verification/testbench.sv */
// self-checking bench for the port status and control block
`timescale 1ns/10ps
module testbench;
import tcps_pkg::*;
	typedef struct {logic [31:0] m; logic [31:0] e;} tcps_note_t;
	tcps_note_t notes[$];
	tcps_note_t nt;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, smp = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, got, d;
	logic [1:0] port_cfg = CFG_SRC, if_sel = SEL_HIGH, cur_sel = 2'h0, rp_lvl = 2'h0;
	logic role_source = 1'b0, attached_src = 1'b0, attached_snk = 1'b0, ocp_req = 1'b0;
	logic [2:0] kind = 3'h0;
	logic [7:0] vbus_lag = 8'h10;
	logic [31:0] prdata, pv;
	logic pready, pslverr, bus_power_sense, vconn_ocp, vconn_cc1_en, vconn_cc2_en, charge_through_en;
	logic strap_mode, target_addr_bit6, a_drv, a_oe, b_drv, b_oe, au_drv, au_oe;
	logic [2:0] cc1_level, cc2_level;
	logic [1:0] rp_strength;
	int errors = 0, cmp_count = 0, seed = 61502, i;
	// open-drain pins with pull-ups
	wire pin_a = a_oe ? a_drv : 1'b1;
	wire pin_b = b_oe ? b_drv : 1'b1;
	wire pin_au = au_oe ? au_drv : 1'b1;
	assign pv = {22'h0, a_drv, b_drv, au_drv, charge_through_en, vconn_cc1_en, vconn_cc2_en,
		target_addr_bit6, strap_mode, rp_strength};
	// clock generator
	initial begin
		forever #20 pclk = ~pclk;
	end
	tcps_port_status i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cc1_level(cc1_level), .cc2_level(cc2_level), .port_cfg(port_cfg), .if_sel(if_sel), .cur_sel(cur_sel),
		.bus_power_sense(bus_power_sense), .vconn_ocp(vconn_ocp), .role_source(role_source),
		.attached_src(attached_src), .attached_snk(attached_snk), .rp_strength(rp_strength),
		.vconn_cc1_en(vconn_cc1_en), .vconn_cc2_en(vconn_cc2_en), .charge_through_en(charge_through_en),
		.strap_mode(strap_mode), .target_addr_bit6(target_addr_bit6), .current_code_out_a_in(pin_a),
		.current_code_out_a_drv(a_drv), .current_code_out_a_oe(a_oe), .current_code_out_b_in(pin_b),
		.current_code_out_b_drv(b_drv), .current_code_out_b_oe(b_oe), .audio_detect_out_in(pin_au),
		.audio_detect_out_drv(au_drv), .audio_detect_out_oe(au_oe));
	tcps_far_port i_far (.pclk(pclk), .presetn(presetn), .kind(kind), .rp_lvl(rp_lvl), .vbus_lag(vbus_lag),
		.ocp_req(ocp_req), .cc1_level(cc1_level), .cc2_level(cc2_level), .bus_power_sense(bus_power_sense),
		.vconn_ocp(vconn_ocp));
	task automatic close_out;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// results are matched against the oldest note
	always @(posedge pclk) begin
		if ((psel && penable && pready && !pwrite) || smp) begin
			got = smp ? pv : prdata;
			nt = notes.pop_front();
			cmp_count++;
			if ((got & nt.m) !== nt.e) begin
				errors++;
				$display("Error at %0t: got %h expected %h", $time, got & nt.m, nt.e);
			end
		end
	end
	// every access phase: error answer exactly for unmapped offsets
	always @(posedge pclk) begin
		if (psel && penable && pready) begin
			cmp_count++;
			if (pslverr !== !(paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_FLAGS, ADDR_PINS})) begin
				errors++;
				$display("Error at %0t: pslverr %h expected %h", $time, pslverr, !pslverr);
			end
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic settle;
		tick(2700); // cc debounce plus sync
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int k;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 50) begin
			errors++;
			close_out();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		notes.push_back('{m, e});
		apb(a, 1'b0, 32'h0);
	endtask
	task automatic probe(input logic [31:0] m, input logic [31:0] e);
		notes.push_back('{m, e});
		@(posedge pclk);
		smp <= 1'b1;
		@(posedge pclk);
		smp <= 1'b0;
	endtask
	task automatic boot(input logic [1:0] s);
		@(posedge pclk);
		presetn <= 1'b0;
		if_sel <= s;
		tick(16);
		presetn <= 1'b1;
		tick(8);
		apb(ADDR_FLAGS, 1'b1, 32'h3);
	endtask
	task automatic fault;
		ocp_req <= 1'b1;
		tick(3);
		ocp_req <= 1'b0;
		tick(10);
	endtask
	// main sequence
	initial begin
		boot(SEL_HIGH);
		if_sel <= SEL_LOW;
		tick(10);
		rd(ADDR_STATUS, 32'h300, 32'h200);
		probe(32'hC, 32'h8);
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		d = $random(seed);
		apb(ADDR_CTRL, 1'b1, d);
		rd(ADDR_CTRL, 32'h3, d & 32'h3);
		apb(ADDR_CTRL, 1'b1, 32'h2);
		port_cfg <= CFG_SRC;
		role_source <= 1'b1;
		kind <= 3'h2;
		settle();
		probe(32'h3F3, 32'h0);
		attached_src <= 1'b1;
		tick(6);
		probe(32'h3F3, 32'h12);
		rd(ADDR_FLAGS, 32'h1, 32'h1);
		rd(ADDR_PINS, 32'h1, 32'h0);
		apb(ADDR_FLAGS, 1'b1, 32'h1); // host clears
		tick(6);
		rd(ADDR_FLAGS, 32'h1, 32'h0);
		rd(ADDR_PINS, 32'h1, 32'h1);
		fault();
		probe(32'h30, 32'h0);
		rd(ADDR_STATUS, 32'h420, 32'h400);
		rd(ADDR_FLAGS, 32'h2, 32'h2);
		tick(40);
		probe(32'h30, 32'h0);
		apb(ADDR_FLAGS, 1'b1, 32'h2);
		tick(6);
		probe(32'h30, 32'h10);
		kind <= 3'h0;
		attached_src <= 1'b0;
		settle();
		rd(ADDR_STATUS, 32'h20, 32'h0);
		for (i = 0; i < 4; i++) begin
			port_cfg <= (i == 1) ? CFG_DRP : CFG_SRC;
			kind <= (i < 2) ? 3'h4 : ((i == 2) ? 3'h3 : 3'h7);
			settle();
			rd(ADDR_STATUS, 32'h1C, {27'h0, (i < 2) ? ACC_DBG_SRC : ((i == 2) ? ACC_AUDIO : ACC_NONE), 2'h0});
			probe(32'h40, (i == 0) ? 32'h40 : 32'h0);
		end
		port_cfg <= CFG_SNK;
		role_source <= 1'b0;
		vbus_lag <= 8'($unsigned($random(seed)) % 200);
		rp_lvl <= CUR_MED;
		kind <= 3'h5;
		settle();
		attached_snk <= 1'b1;
		tick(6);
		rd(ADDR_STATUS, 32'h43, {25'h0, 1'b1, 4'h0, CUR_MED});
		attached_snk <= 1'b0;
		kind <= 3'h6;
		settle();
		rd(ADDR_STATUS, 32'h1C, {27'h0, ACC_DBG_SNK, 2'h0});
		boot(SEL_FLOAT);
		probe(32'h4, 32'h4);
		kind <= 3'h5;
		attached_snk <= 1'b1;
		for (i = 0; i < 3; i++) begin
			rp_lvl <= 2'(i);
			settle();
			rd(ADDR_PINS, 32'h6, (i == 0) ? 32'h6 : ((i == 1) ? 32'h2 : 32'h0));
		end
		attached_snk <= 1'b0;
		port_cfg <= CFG_SRC;
		role_source <= 1'b1;
		kind <= 3'h2;
		settle();
		attached_src <= 1'b1;
		apb(ADDR_CTRL, 1'b1, 32'h0);
		for (i = 0; i < 3; i++) begin
			cur_sel <= 2'(i);
			tick(8);
			probe(32'h3, i);
		end
		probe(32'h30, 32'h10);
		fault();
		apb(ADDR_FLAGS, 1'b1, 32'h3);
		tick(6);
		probe(32'h30, 32'h0);
		attached_src <= 1'b0;
		tick(4);
		attached_src <= 1'b1;
		tick(6);
		probe(32'h30, 32'h10);
		attached_src <= 1'b0;
		kind <= 3'h3;
		settle();
		rd(ADDR_PINS, 32'h1, 32'h0);
		close_out();
	end
endmodule // testbench
